// ---- mmf_defines.vh ----
// What this block does
// - Mask view is read-only, one bit per source, set means source masked.
// - Mask bits 1..7: rx complete, rx used, tx used, underrun, retry, exhausted, tx done.
// - Mask view shows receive overrun at bit 10 and bus error at bit 11.
// - Pause frame seen at bit 12, pause time zero at 13, management done at bit 0; others read zero.
// - A finished PHY read loads returned data into management bits 15:0.
// - Turnaround code at bits 17:16 is written 10 and reads back as written.
// - Operation bits 29:28: 10 reads, 01 writes, anything else is invalid.
// - PHY address sits at bits 27:23, PHY register address at 22:18.
// - Pause count is 16-bit read/write, decremented every 512 bit times.
// - A 64-bit hash filter applied to every destination address; low register holds hash bits 31:0.
// - High hash register holds hash bits 63:32.
// - Address low register holds destination bits 31:0; bit 0 is multicast flag.
// - Address high register holds destination bits 47:32 in its low 16 bits.
// - Management done flag sets when a PHY operation ends; status read clears it.
// - Pause time zero flag sets when the count reaches zero; status read clears it.
`ifndef MMF_DEFINES_VH
`define MMF_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MMF_OFS_STATUS   8'h00
`define MMF_OFS_MASKVIEW 8'h04
`define MMF_OFS_UNMASK   8'h08
`define MMF_OFS_MASK     8'h0C
`define MMF_OFS_MGMT     8'h10
`define MMF_OFS_PAUSE    8'h14
`define MMF_OFS_HASH_LO  8'h18
`define MMF_OFS_HASH_HI  8'h1C
`define MMF_OFS_DA1_LO   8'h20
`define MMF_OFS_DA1_HI   8'h24
`define MMF_OFS_DA2_LO   8'h28
`define MMF_OFS_DA2_HI   8'h2C
`define MMF_OFS_CTRL     8'h30

// ----------------------------------------------------------------
// Interrupt source bit positions
// ----------------------------------------------------------------
`define MMF_IRQ_MGMT_DONE  0
`define MMF_IRQ_RX_DONE    1
`define MMF_IRQ_RX_USED    2
`define MMF_IRQ_TX_USED    3
`define MMF_IRQ_TX_UNDER   4
`define MMF_IRQ_RETRY      5
`define MMF_IRQ_TX_EXH     6
`define MMF_IRQ_TX_DONE    7
`define MMF_IRQ_RX_OVR     10
`define MMF_IRQ_BUS_ERR    11
`define MMF_IRQ_PAUSE_SEEN 12
`define MMF_IRQ_PAUSE_ZERO 13
`define MMF_IRQ_VALID      32'h00003CFF

// ----------------------------------------------------------------
// Management frame fields and codes
// ----------------------------------------------------------------
`define MMF_MGMT_SOF_HI  31
`define MMF_MGMT_SOF_LO  30
`define MMF_MGMT_OP_HI   29
`define MMF_MGMT_OP_LO   28
`define MMF_MGMT_PHY_HI  27
`define MMF_MGMT_PHY_LO  23
`define MMF_MGMT_REG_HI  22
`define MMF_MGMT_REG_LO  18
`define MMF_MGMT_TA_HI   17
`define MMF_MGMT_TA_LO   16
`define MMF_MGMT_SOF_OK  2'h1
`define MMF_MGMT_OP_RD   2'h2
`define MMF_MGMT_OP_WR   2'h1
`define MMF_MGMT_TA_BIT  6'h2E
`define MMF_MGMT_RD_BIT  6'h30
`define MMF_MGMT_LAST    6'h3F
`define MMF_PREAMBLE     32'hFFFFFFFF

// ----------------------------------------------------------------
// Control bits, reset values and timing
// ----------------------------------------------------------------
`define MMF_CTRL_DA1_EN  0
`define MMF_CTRL_DA2_EN  1
`define MMF_CTRL_BUSY    2
`define MMF_PAUSE_BITS   512
`define MMF_RESET_ZERO   32'h00000000
`define MMF_MDC_HALF_NS  40
`define MMF_CLK_NS       10

`endif

// ---- mmf_phy.sv ----
`timescale 1ns/100ps
`default_nettype none
module mmf_phy #(parameter logic [15:0] RD = 16'h1234) (
    // Management pins seen from the PHY
    input wire logic        mdc, mdio_out, mdio_oe_n,
    output wire logic       mdio_in,
    output var logic [31:0] frame
);
    int   idx = 0;
    logic drv = 0, b = 1;
    // Pin level: MAC while enabled, else PHY, else pull-up
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? b : 1'b1);
    // Frame start clears the count; each rising mdc counts and captures a driven bit
    always @(posedge mdc or negedge mdio_oe_n)
    begin
        if (!mdc) idx <= 0;
        else
        begin
            idx <= idx + 1;
            if (!mdio_oe_n) frame <= {frame[30:0], mdio_out};
        end
    end
    // Turnaround zero then read data, MSB first, changed on falling mdc
    always @(negedge mdc)
    begin
        drv <= idx > 46 && idx < 64;
        b <= (idx > 47 && idx < 64) ? RD[63 - idx] : 1'b0;
    end
endmodule // mmf_phy
`default_nettype wire

// ---- mmf_regs.v ----
`timescale 1ns/100ps
`default_nettype none
`include "mmf_defines.vh"

module mmf_regs
#(
    parameter MDC_HALF = `MMF_MDC_HALF_NS / `MMF_CLK_NS,
    parameter PAUSE_Q  = `MMF_PAUSE_BITS
)
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Event pulses from the MAC core
    input  wire        rx_complete,
    input  wire        rx_used_bit_seen,
    input  wire        tx_used_bit_seen,
    input  wire        tx_underrun,
    input  wire        retry_limit_hit,
    input  wire        tx_buffers_exhausted,
    input  wire        tx_complete,
    input  wire        rx_overrun,
    input  wire        bus_error,
    input  wire        pause_frame_seen,
    // Line bit-time tick and received destination address
    input  wire        bit_tick,
    input  wire [47:0] rx_dest_addr,
    input  wire        rx_dest_valid,
    output reg         rx_addr_match,
    output reg         rx_match_valid,
    // Serial management pins
    output reg         mdc,
    input  wire        mdio_in,
    output reg         mdio_out,
    output reg         mdio_oe_n,
    // Interrupt
    output wire        irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam ST_IDLE  = 1'b0;
    localparam ST_SHIFT = 1'b1;
    localparam [1:0] RESP_OK  = 2'h0;
    localparam [1:0] RESP_ERR = 2'h2;
    localparam [15:0] HALF_CNT = (MDC_HALF < 1) ? 16'h0001 : MDC_HALF[15:0];
    localparam [9:0]  PQ_LAST  = PAUSE_Q[9:0] - 10'h001;

    reg  [7:0]  aw_addr_reg;
    reg         aw_full_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_full_reg;
    reg  [31:0] status_reg;
    reg  [31:0] enable_reg;
    reg  [31:0] mgmt_reg;
    reg  [15:0] pause_count_reg;
    reg  [9:0]  pause_div_reg;
    reg  [31:0] hash_lo_reg;
    reg  [31:0] hash_hi_reg;
    reg  [31:0] da1_lo_reg;
    reg  [15:0] da1_hi_reg;
    reg  [31:0] da2_lo_reg;
    reg  [15:0] da2_hi_reg;
    reg  [1:0]  ctrl_reg;
    reg         state_reg;
    reg  [63:0] shift_reg;
    reg  [5:0]  bit_reg;
    reg  [15:0] half_reg;
    reg         is_read_reg;
    reg  [15:0] rd_data_reg;
    reg         mdio_s1_reg;
    reg         mdio_s2_reg;
    reg  [31:0] rdata_next;
    reg         rerr_next;
    reg  [31:0] events;

    wire        wr_go;
    wire        rd_go;
    wire [31:0] mask_view;
    wire        wr_mgmt;
    wire        frame_ok;
    wire        mgmt_done;
    wire        pause_zero;
    wire        bit_end;
    wire        wr_err;
    wire [5:0]  hash_idx;
    wire [63:0] hash_all;

    // Byte-lane merge of a write into an old register value
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    // Low-half byte-lane merge for the 16-bit registers
    function [15:0] merge16;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
        end
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
    assign wr_err = (aw_addr_reg[1:0] != 2'h0) || (aw_addr_reg > `MMF_OFS_CTRL)
                    || (aw_addr_reg == `MMF_OFS_STATUS)
                    || (aw_addr_reg == `MMF_OFS_MASKVIEW);
    assign wr_mgmt = wr_go & ~wr_err & (aw_addr_reg == `MMF_OFS_MGMT)
                     & (state_reg == ST_IDLE);

    // Address and data capture in either order, response after both
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr_reg  <= 8'h00;
            aw_full_reg  <= 1'b0;
            w_data_reg   <= `MMF_RESET_ZERO;
            w_strb_reg   <= 4'h0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            if (wr_go)
            begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_err ? RESP_ERR : RESP_OK;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------
    assign mask_view = ~enable_reg & `MMF_IRQ_VALID;
    assign irq = |(status_reg & enable_reg);

    // Event vector in the documented bit order
    always @*
    begin
        events = `MMF_RESET_ZERO;
        events[`MMF_IRQ_MGMT_DONE]  = mgmt_done;
        events[`MMF_IRQ_RX_DONE]    = rx_complete;
        events[`MMF_IRQ_RX_USED]    = rx_used_bit_seen;
        events[`MMF_IRQ_TX_USED]    = tx_used_bit_seen;
        events[`MMF_IRQ_TX_UNDER]   = tx_underrun;
        events[`MMF_IRQ_RETRY]      = retry_limit_hit;
        events[`MMF_IRQ_TX_EXH]     = tx_buffers_exhausted;
        events[`MMF_IRQ_TX_DONE]    = tx_complete;
        events[`MMF_IRQ_RX_OVR]     = rx_overrun;
        events[`MMF_IRQ_BUS_ERR]    = bus_error;
        events[`MMF_IRQ_PAUSE_SEEN] = pause_frame_seen;
        events[`MMF_IRQ_PAUSE_ZERO] = pause_zero;
    end

    // Sticky status; a new event wins over the clear of the read
    always @(posedge aclk)
    begin
        if (!aresetn)
            status_reg <= `MMF_RESET_ZERO;
        else if (rd_go && s_axi_araddr == `MMF_OFS_STATUS)
            status_reg <= events;
        else
            status_reg <= status_reg | events;
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg  <= `MMF_RESET_ZERO;
            mgmt_reg    <= `MMF_RESET_ZERO;
            hash_lo_reg <= `MMF_RESET_ZERO;
            hash_hi_reg <= `MMF_RESET_ZERO;
            da1_lo_reg  <= `MMF_RESET_ZERO;
            da1_hi_reg  <= 16'h0000;
            da2_lo_reg  <= `MMF_RESET_ZERO;
            da2_hi_reg  <= 16'h0000;
            ctrl_reg    <= 2'h0;
        end
        else
        begin
            if (wr_go && !wr_err)
            begin
                case (aw_addr_reg)
                    `MMF_OFS_UNMASK:
                        enable_reg <= (enable_reg | merge(32'h0, w_data_reg, w_strb_reg))
                                      & `MMF_IRQ_VALID;
                    `MMF_OFS_MASK:
                        enable_reg <= enable_reg & ~merge(32'h0, w_data_reg, w_strb_reg);
                    `MMF_OFS_HASH_LO:
                        hash_lo_reg <= merge(hash_lo_reg, w_data_reg, w_strb_reg);
                    `MMF_OFS_HASH_HI:
                        hash_hi_reg <= merge(hash_hi_reg, w_data_reg, w_strb_reg);
                    `MMF_OFS_DA1_LO:
                        da1_lo_reg <= merge(da1_lo_reg, w_data_reg, w_strb_reg);
                    `MMF_OFS_DA1_HI:
                        da1_hi_reg <= merge16(da1_hi_reg, w_data_reg[15:0],
                                              w_strb_reg[1:0]);
                    `MMF_OFS_DA2_LO:
                        da2_lo_reg <= merge(da2_lo_reg, w_data_reg, w_strb_reg);
                    `MMF_OFS_DA2_HI:
                        da2_hi_reg <= merge16(da2_hi_reg, w_data_reg[15:0],
                                              w_strb_reg[1:0]);
                    `MMF_OFS_CTRL:
                        ctrl_reg <= w_strb_reg[0] ? w_data_reg[1:0] : ctrl_reg;
                    default:
                        ctrl_reg <= ctrl_reg;
                endcase
            end
            // Fields stored as written, code and address included
            if (wr_mgmt)
                mgmt_reg <= merge(mgmt_reg, w_data_reg, w_strb_reg);
            else if (mgmt_done && is_read_reg)
                mgmt_reg[15:0] <= rd_data_reg;
        end
    end

    // ------------------------------------------------------------
    // Pause time counter
    // ------------------------------------------------------------
    assign pause_zero = bit_tick && (pause_div_reg == PQ_LAST)
                        && (pause_count_reg == 16'h0001) && !(wr_go && !wr_err
                        && aw_addr_reg == `MMF_OFS_PAUSE);

    // Software load, otherwise one step down per 512 bit ticks
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pause_count_reg <= 16'h0000;
            pause_div_reg   <= 10'h000;
        end
        else if (wr_go && !wr_err && aw_addr_reg == `MMF_OFS_PAUSE)
        begin
            pause_count_reg <= merge16(pause_count_reg, w_data_reg[15:0],
                                       w_strb_reg[1:0]);
            pause_div_reg   <= 10'h000;
        end
        else if (bit_tick && pause_count_reg != 16'h0000)
        begin
            if (pause_div_reg == PQ_LAST)
            begin
                pause_div_reg   <= 10'h000;
                pause_count_reg <= pause_count_reg - 16'h0001;
            end
            else
                pause_div_reg <= pause_div_reg + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------
    always @*
    begin
        rerr_next  = 1'b0;
        rdata_next = `MMF_RESET_ZERO;
        case (s_axi_araddr)
            `MMF_OFS_STATUS:   rdata_next = status_reg;
            `MMF_OFS_MASKVIEW: rdata_next = mask_view;
            `MMF_OFS_MGMT:     rdata_next = mgmt_reg;
            `MMF_OFS_PAUSE:    rdata_next = {16'h0000, pause_count_reg};
            `MMF_OFS_HASH_LO:  rdata_next = hash_lo_reg;
            `MMF_OFS_HASH_HI:  rdata_next = hash_hi_reg;
            `MMF_OFS_DA1_LO:   rdata_next = da1_lo_reg;
            `MMF_OFS_DA1_HI:   rdata_next = {16'h0000, da1_hi_reg};
            `MMF_OFS_DA2_LO:   rdata_next = da2_lo_reg;
            `MMF_OFS_DA2_HI:   rdata_next = {16'h0000, da2_hi_reg};
            `MMF_OFS_CTRL:     rdata_next = {29'h0, state_reg, ctrl_reg};
            `MMF_OFS_UNMASK:   rdata_next = `MMF_RESET_ZERO;
            `MMF_OFS_MASK:     rdata_next = `MMF_RESET_ZERO;
            default:           rerr_next  = 1'b1;
        endcase
    end

    // Read answer registered one cycle after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `MMF_RESET_ZERO;
            s_axi_rresp  <= RESP_OK;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_next;
            s_axi_rresp  <= rerr_next ? RESP_ERR : RESP_OK;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // Serial management engine
    // ------------------------------------------------------------
    assign frame_ok = (w_data_reg[`MMF_MGMT_SOF_HI:`MMF_MGMT_SOF_LO] == `MMF_MGMT_SOF_OK)
                      && ((w_data_reg[`MMF_MGMT_OP_HI:`MMF_MGMT_OP_LO] == `MMF_MGMT_OP_RD)
                      || (w_data_reg[`MMF_MGMT_OP_HI:`MMF_MGMT_OP_LO] == `MMF_MGMT_OP_WR));
    assign bit_end   = (half_reg == HALF_CNT - 16'h0001) && mdc;
    assign mgmt_done = (state_reg == ST_SHIFT) && bit_end && (bit_reg == `MMF_MGMT_LAST);

    // Input synchroniser for the data pin
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mdio_s1_reg <= 1'b1;
            mdio_s2_reg <= 1'b1;
        end
        else
        begin
            mdio_s1_reg <= mdio_in;
            mdio_s2_reg <= mdio_s1_reg;
        end
    end

    // Preamble then frame, clock low half drives, rising edge samples
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg   <= ST_IDLE;
            shift_reg   <= {`MMF_PREAMBLE, `MMF_RESET_ZERO};
            bit_reg     <= 6'h00;
            half_reg    <= 16'h0000;
            is_read_reg <= 1'b0;
            rd_data_reg <= 16'h0000;
            mdc         <= 1'b0;
            mdio_out    <= 1'b1;
            mdio_oe_n   <= 1'b1;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    mdc       <= 1'b0;
                    mdio_oe_n <= 1'b1;
                    // Invalid start or operation codes send nothing
                    if (wr_mgmt && frame_ok)
                    begin
                        state_reg   <= ST_SHIFT;
                        shift_reg   <= {`MMF_PREAMBLE, merge(mgmt_reg, w_data_reg,
                                        w_strb_reg)};
                        is_read_reg <= (w_data_reg[`MMF_MGMT_OP_HI:`MMF_MGMT_OP_LO]
                                        == `MMF_MGMT_OP_RD);
                        bit_reg     <= 6'h00;
                        half_reg    <= 16'h0000;
                        mdio_out    <= 1'b1;
                        mdio_oe_n   <= 1'b0;
                    end
                end
                ST_SHIFT:
                begin
                    mdio_out  <= shift_reg[63];
                    mdio_oe_n <= is_read_reg && (bit_reg >= `MMF_MGMT_TA_BIT);
                    if (half_reg == HALF_CNT - 16'h0001)
                    begin
                        half_reg <= 16'h0000;
                        mdc      <= ~mdc;
                        // Rising edge: capture read data bits
                        if (!mdc && is_read_reg && bit_reg >= `MMF_MGMT_RD_BIT)
                            rd_data_reg <= {rd_data_reg[14:0], mdio_s2_reg};
                        if (mdc)
                        begin
                            shift_reg <= {shift_reg[62:0], 1'b0};
                            bit_reg   <= bit_reg + 6'h01;
                            if (bit_reg == `MMF_MGMT_LAST)
                                state_reg <= ST_IDLE;
                        end
                    end
                    else
                        half_reg <= half_reg + 16'h0001;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Destination address filter
    // ------------------------------------------------------------
    assign hash_all = {hash_hi_reg, hash_lo_reg};

    // Hash index bit i is the xor of every sixth address bit from i
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1)
        begin : g_hash
            assign hash_idx[gi] = rx_dest_addr[gi] ^ rx_dest_addr[gi + 6]
                                ^ rx_dest_addr[gi + 12] ^ rx_dest_addr[gi + 18]
                                ^ rx_dest_addr[gi + 24] ^ rx_dest_addr[gi + 30]
                                ^ rx_dest_addr[gi + 36] ^ rx_dest_addr[gi + 42];
        end
    endgenerate

    // Registered match result, one cycle after the address arrives
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_addr_match  <= 1'b0;
            rx_match_valid <= 1'b0;
        end
        else
        begin
            rx_match_valid <= rx_dest_valid;
            if (rx_dest_valid)
                rx_addr_match <= (ctrl_reg[`MMF_CTRL_DA1_EN]
                                  && rx_dest_addr == {da1_hi_reg, da1_lo_reg})
                              || (ctrl_reg[`MMF_CTRL_DA2_EN]
                                  && rx_dest_addr == {da2_hi_reg, da2_lo_reg})
                              || hash_all[hash_idx];
        end
    end

endmodule // mmf_regs

`default_nettype wire

// ---- mmf_regs_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module mmf_regs_chk (
    // Clock, reset and observed handshakes
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready, rx_dest_valid, rx_match_valid,
    input wire logic rx_addr_match, irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw: assert property (p_aw) else $error("awready high after take");
    property p_bw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_bw: assert property (p_bw) else $error("write ready during response");
    property p_bh; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid after handshake");
    property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar: assert property (p_ar) else $error("read data late");
    property p_rb; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rb: assert property (p_rb) else $error("arready during read data");
    property p_rh; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rh: assert property (p_rh) else $error("rvalid after handshake");
    property p_mv; rx_dest_valid |=> rx_match_valid; endproperty
    a_mv: assert property (p_mv) else $error("match result late");
    property p_m1; rx_match_valid |-> $past(rx_dest_valid); endproperty
    a_m1: assert property (p_m1) else $error("match result without address");
    c_hit: cover property (rx_match_valid && rx_addr_match);
    c_irq: cover property ($rose(irq));
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // mmf_regs_chk
bind mmf_regs mmf_regs_chk u_chk (.*);
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mmf_defines.vh"
module tb_top;
    // Stimulus, events and observed outputs
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, rx_dest_valid = 0, bit_tick = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, q;
    logic [47:0] rx_dest_addr = 0;
    logic [9:0] ev = 0;
    wire rx_complete, rx_used_bit_seen, tx_used_bit_seen, tx_underrun, retry_limit_hit;
    wire tx_buffers_exhausted, tx_complete, rx_overrun, bus_error, pause_frame_seen, irq, mdc;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire rx_addr_match, rx_match_valid, mdio_in, mdio_out, mdio_oe_n;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, frame;
    int fails = 0, compares = 0;
    assign {pause_frame_seen, bus_error, rx_overrun, tx_complete, tx_buffers_exhausted,
            retry_limit_hit, tx_underrun, tx_used_bit_seen, rx_used_bit_seen, rx_complete} = ev;
    always #5 aclk = ~aclk;
    always @(posedge aclk) bit_tick <= ~bit_tick;
    mmf_regs #(.PAUSE_Q(4)) DUT (.*);
    mmf_phy PHY (.*);
    task test_done;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin fails++; $display("Error %0t: got %h want %h", $time, g, e); end
    endtask
    task hang(input int n);
        if (n > 2999) begin fails++; $display("Error %0t: wait timed out", $time); test_done; end
    endtask
    // Register write, both channels offered together
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 3000 && s_axi_bvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0; hang(n);
        chk(s_axi_bresp, (a < 8'h08 || a > 8'h30 || a[1:0] != 2'h0) ? 2 : 0);
    endtask
    // Register read compared with an expected word
    task rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        for (n = 0; n < 3000 && s_axi_rvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0; q = s_axi_rdata; hang(n); chk(q, e);
        chk(s_axi_rresp, 0);
    endtask
    task wirq;
        int n;
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge aclk);
        hang(n);
    endtask
    task pr(input logic [47:0] a, input logic e);
        @(posedge aclk); rx_dest_addr <= a; rx_dest_valid <= 1;
        @(posedge aclk); rx_dest_valid <= 0;
        @(posedge aclk); chk({rx_match_valid, rx_addr_match}, {1'b1, e});
    endtask
    task t_irq;
        rd(`MMF_OFS_MASKVIEW, 32'h00003CFF);
        wr(`MMF_OFS_UNMASK, 32'hFFFFFFFF); wr(`MMF_OFS_MASK, 32'h00000C02);
        wr(`MMF_OFS_MASKVIEW, 32'h0);
        rd(`MMF_OFS_MASKVIEW, 32'h00000C02);
        ev <= 10'h3FF; @(posedge aclk); ev <= 10'h0; wirq;
        rd(`MMF_OFS_STATUS, 32'h00001CFE);
        rd(`MMF_OFS_STATUS, 32'h0);
    endtask
    task t_mgmt;
        wr(`MMF_OFS_MGMT, 32'h528EA5C3); wirq; // Write PHY 5 register 3
        chk(frame, 32'h528EA5C3);
        rd(`MMF_OFS_STATUS, 32'h1);
        wr(`MMF_OFS_MGMT, 32'h6F820000); wirq; // Read PHY 31 register 0
        rd(`MMF_OFS_STATUS, 32'h1);
        rd(`MMF_OFS_MGMT, 32'h6F821234);
        wr(`MMF_OFS_MGMT, 32'h4F820000); rd(`MMF_OFS_CTRL, 32'h0);
    endtask
    task t_pause;
        wr(`MMF_OFS_PAUSE, 32'h3); wirq;
        rd(`MMF_OFS_STATUS, 32'h00002000);
        rd(`MMF_OFS_PAUSE, 32'h0);
    endtask
    task t_addr;
        logic [31:0] v [6];
        int i;
        v = '{32'h1, 32'h80000000, 32'h44332211, 32'hFFFF6655, 32'h5678, 32'hFFFFABCD};
        for (i = 0; i < 6; i++) begin
            wr(8'h18 + 8'(4 * i), v[i]);
            rd(8'h18 + 8'(4 * i), (i > 2 && i[0]) ? {16'h0, v[i][15:0]} : v[i]);
        end
        wr(`MMF_OFS_CTRL, 32'h1);
        pr(48'h665544332211, 1'b1);
        pr(48'h0, 1'b1);
        pr(48'h3F, 1'b1);
        pr(48'h1, 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_irq; t_mgmt; t_pause; t_addr;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
